// ### rtl/pmic_seq_pkg.sv
// Constants, field layouts and types for the power fault sequencer
package pmic_seq_pkg;
    localparam int CLK_PERIOD_NS = 40;
    localparam int PG_DELAY_NS = 1000000;
    localparam int OC_FILT_NS = 1024000;
    localparam int REG_OC_NS = 32000;
    localparam int PG_CYCLES = (PG_DELAY_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int OC_CYCLES = (OC_FILT_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int REG_OC_CYCLES = (REG_OC_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int CNT_W = 16;

    localparam int AXI_AW = 8;
    localparam logic [AXI_AW-1:0] ADDR_CTRL = 8'h00;
    localparam logic [AXI_AW-1:0] ADDR_STAT0 = 8'h04;
    localparam logic [AXI_AW-1:0] ADDR_STAT1 = 8'h08;
    localparam logic [AXI_AW-1:0] ADDR_LIVE = 8'h0c;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CTRL_DIS_EN_BIT = 0;
    localparam logic CTRL_DIS_EN_RESET = 1'h0;

    // Flat 16-bit status: low byte is status 0, high byte status 1
    localparam int ST_EOTW5 = 0;
    localparam int ST_EOTW12 = 1;
    localparam int ST_OT5 = 2;
    localparam int ST_OT12 = 3;
    localparam int ST_UV_CORE = 4;
    localparam int ST_UV_IO = 5;
    localparam int ST_UV5 = 6;
    localparam int ST_TWELVE_UNDERVOLTAGE_FLAG = 7;
    localparam int ST_OV5 = 8;
    localparam int ST_TWELVE_OVERVOLTAGE_FLAG = 9;
    localparam int ST_PDIS = 11;
    localparam int ST_OC_CORE = 12;
    localparam int ST_OC_IO = 13;
    localparam int ST_OC5 = 14;
    localparam int ST_OC12 = 15;
    localparam logic [15:0] STAT_LOCK_MASK = 16'hcfff;
    localparam logic [15:0] STAT_RESET = 16'h0000;

    // Filter channels
    localparam int F_IO_PG = 0;
    localparam int F_CORE_PG = 1;
    localparam int F_PG = 2;
    localparam int F_LDO = 3;
    localparam int F_OC5 = 4;
    localparam int F_OC12 = 5;
    localparam int F_OC_CORE = 6;
    localparam int F_OC_IO = 7;
    localparam int F_EW5 = 8;
    localparam int F_EW12 = 9;
    localparam int NF = 10;

    typedef struct packed {
        logic five_good;
        logic twelve_good;
        logic rev_fast;
        logic core_en_pin;
        logic core_above;
        logic io_above;
        logic io_ss_done;
        logic twelve_settled;
        logic ot5;
        logic ot12;
        logic eotw5;
        logic eotw12;
        logic oc5;
        logic oc12;
        logic oc_core;
        logic oc_io;
        logic clamp5;
        logic clamp12;
        logic pdis;
        logic permit;
    } sense_t;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_IO_UP, SEQ_CORE} seq_t;
endpackage : pmic_seq_pkg

// ### rtl/pmic_fault_sequencer.sv
// Power sequencing, fault latching and alert logic with AXI4-Lite access
`timescale 1ns/1ps
module pmic_fault_sequencer
    import pmic_seq_pkg::*;
#(
    parameter int PG_DELAY = PG_CYCLES,
    parameter int OC_DELAY = OC_CYCLES
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [AXI_AW-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AXI_AW-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic five_volt_input_good,
    input wire logic twelve_volt_input_good,
    input wire logic reverse_current_fast,
    input wire logic core_reg_enable_pin,
    input wire logic core_above_threshold,
    input wire logic io_above_threshold,
    input wire logic io_soft_start_done,
    input wire logic twelve_output_settled,
    input wire logic five_over_temperature,
    input wire logic twelve_over_temperature,
    input wire logic five_early_thermal_warning,
    input wire logic twelve_early_thermal_warning,
    input wire logic five_fuse_current_limit,
    input wire logic twelve_fuse_current_limit,
    input wire logic core_current_limit,
    input wire logic io_current_limit,
    input wire logic five_output_clamp,
    input wire logic twelve_output_clamp,
    input wire logic power_disable_pin,
    input wire logic fw_disable_permit_pin,
    output logic five_volt_fuse,
    output logic twelve_volt_fuse,
    output logic io_regulator_enable,
    output logic core_regulator_enable,
    output logic power_good_out,
    output logic core_power_good,
    output logic backup_ldo_enable,
    output logic fault_alert_n
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////
    // Input synchronisers
    sense_t raw, s1, s, sp;
    assign raw = '{five_volt_input_good, twelve_volt_input_good,
        reverse_current_fast, core_reg_enable_pin, core_above_threshold,
        io_above_threshold, io_soft_start_done, twelve_output_settled,
        five_over_temperature, twelve_over_temperature,
        five_early_thermal_warning, twelve_early_thermal_warning,
        five_fuse_current_limit, twelve_fuse_current_limit,
        core_current_limit, io_current_limit, five_output_clamp,
        twelve_output_clamp, power_disable_pin, fw_disable_permit_pin};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1 <= '0;
            s <= '0;
            sp <= '0;
        end else begin
            s1 <= raw;
            s <= s1;
            sp <= s;
        end
    end

    wire five_rise = s.five_good & ~sp.five_good;
    wire five_fall = ~s.five_good & sp.five_good;
    wire twelve_rise = s.twelve_good & ~sp.twelve_good;
    wire twelve_fall = ~s.twelve_good & sp.twelve_good;
    wire pdis_rise = s.pdis & ~sp.pdis;
    wire pdis_fall = ~s.pdis & sp.pdis;

    ////////////////////////////////////////////////////////////////////
    // Release-cycle detection and thermal latch-off
    logic five_fell, twelve_fell, pdis_rose;
    logic latch5, latch12;
    wire five_cycled = five_rise & five_fell;
    wire twelve_cycled = twelve_rise & twelve_fell;
    wire pdis_cycled = pdis_fall & pdis_rose;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            five_fell <= 1'b0;
            twelve_fell <= 1'b0;
            pdis_rose <= 1'b0;
        end else begin
            five_fell <= five_fall | (five_fell & ~five_rise);
            twelve_fell <= twelve_fall | (twelve_fell & ~twelve_rise);
            pdis_rose <= pdis_rise | (pdis_rose & ~pdis_fall);
        end
    end

    // Set wins: a cycle finishing while still hot keeps the latch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            latch5 <= 1'b0;
            latch12 <= 1'b0;
        end else begin
            latch12 <= s.ot12 | (latch12 & ~(twelve_cycled | pdis_cycled
                | five_cycled));
            latch5 <= s.ot5 | (latch5 & ~(five_cycled
                | pdis_cycled));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Power-disable decode and fuse control
    logic dis_en, twelve_run;
    wire pdis_open = s.permit ? (dis_en & s.pdis) : s.pdis;
    wire next_five_fuse = s.five_good & ~s.rev_fast
        & ~latch5 & ~pdis_open;
    // 12V may stay up on its own once started; it cannot start alone
    wire next_twelve_run = s.twelve_good & ~latch12 & ~pdis_open
        & (twelve_run | s.five_good);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            five_volt_fuse <= 1'b0;
            twelve_run <= 1'b0;
        end else begin
            five_volt_fuse <= next_five_fuse;
            twelve_run <= next_twelve_run;
        end
    end
    assign twelve_volt_fuse = twelve_run;

    ////////////////////////////////////////////////////////////////////
    // Persistence filters and one-shot timers
    wire [NF-1:0] fout;
    logic [NF-1:0] fin, fprev;
    logic late5;
    wire backup_want = s.io_ss_done & ~late5;

    always_comb begin
        fin = '0;
        fin[F_IO_PG] = s.io_above & io_regulator_enable;
        fin[F_CORE_PG] = s.core_above & core_regulator_enable;
        fin[F_PG] = s.io_above & s.core_above;
        fin[F_LDO] = backup_want;
        fin[F_OC5] = s.oc5;
        fin[F_OC12] = s.oc12;
        fin[F_OC_CORE] = s.oc_core;
        fin[F_OC_IO] = s.oc_io;
        fin[F_EW5] = s.eotw5;
        fin[F_EW12] = s.eotw12;
    end

    for (genvar i = 0; i < NF; i++) begin : g_filt
        localparam int LIM = (i <= F_LDO) ? PG_DELAY
            : (i <= F_OC12) ? OC_DELAY : REG_OC_CYCLES;
        // Only the backup enable is filtered in both directions
        localparam bit FAST_OFF = (i != F_LDO);
        logic [CNT_W-1:0] cnt;
        logic q;
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cnt <= '0;
                q <= 1'b0;
            end else if (fin[i] == q) begin
                cnt <= '0;
            end else if (FAST_OFF && !fin[i]) begin
                cnt <= '0;
                q <= 1'b0;
            end else if (cnt == CNT_W'(LIM - 1)) begin
                cnt <= '0;
                q <= fin[i];
            end else begin
                cnt <= cnt + 1'b1;
            end
        end
        assign fout[i] = q;
    end

    wire [NF-1:0] frise = fout & ~fprev;
    assign power_good_out = fout[F_PG];
    assign core_power_good = fout[F_CORE_PG];
    assign backup_ldo_enable = fout[F_LDO];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fprev <= '0;
            late5 <= 1'b0;
        end else begin
            fprev <= fout;
            late5 <= (five_rise & s.twelve_settled)
                | (late5 & ~five_fall);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Regulator start-up sequence
    seq_t seq, next_seq;
    always_comb begin
        next_seq = seq;
        case (seq)
            SEQ_IDLE: if (five_volt_fuse) next_seq = SEQ_IO_UP;
            SEQ_IO_UP: if (fout[F_IO_PG]) next_seq = SEQ_CORE;
            SEQ_CORE: next_seq = SEQ_CORE;
            default: next_seq = SEQ_IDLE;
        endcase
        if (latch5) next_seq = SEQ_IDLE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq <= SEQ_IDLE;
            io_regulator_enable <= 1'b0;
            core_regulator_enable <= 1'b0;
        end else begin
            seq <= next_seq;
            io_regulator_enable <= next_seq != SEQ_IDLE;
            core_regulator_enable <= (next_seq == SEQ_CORE)
                & s.core_en_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Fault status and alert
    logic [15:0] status, evt;
    logic status_wr;
    always_comb begin
        evt = '0;
        evt[ST_EOTW5] = frise[F_EW5];
        evt[ST_EOTW12] = frise[F_EW12];
        evt[ST_OT5] = s.ot5 & ~sp.ot5;
        evt[ST_OT12] = s.ot12 & ~sp.ot12;
        evt[ST_UV_CORE] = ~s.core_above & sp.core_above
            & core_regulator_enable;
        evt[ST_UV_IO] = ~s.io_above & sp.io_above & io_regulator_enable;
        evt[ST_UV5] = five_fall;
        evt[ST_TWELVE_UNDERVOLTAGE_FLAG] = twelve_fall;
        evt[ST_OV5] = s.clamp5 & ~sp.clamp5;
        evt[ST_TWELVE_OVERVOLTAGE_FLAG] = s.clamp12 & ~sp.clamp12;
        evt[ST_PDIS] = s.pdis ^ sp.pdis;
        evt[ST_OC_CORE] = frise[F_OC_CORE];
        evt[ST_OC_IO] = frise[F_OC_IO];
        evt[ST_OC5] = frise[F_OC5];
        evt[ST_OC12] = frise[F_OC12];
    end

    wire locked = |(status & STAT_LOCK_MASK);
    wire [15:0] keep = status_wr ? STAT_RESET : status;
    wire [15:0] gate = (locked & ~status_wr) ? ~STAT_LOCK_MASK : 16'hffff;
    // A fault in the clearing cycle survives the clear
    wire [15:0] next_status = keep | (evt & gate);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= STAT_RESET;
            fault_alert_n <= 1'b1;
        end else begin
            status <= next_status;
            fault_alert_n <= ~|next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    logic aw_got, w_got;
    logic [AXI_AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    assign s_axi_awready = ~aw_got & ~s_axi_bvalid;
    assign s_axi_wready = ~w_got & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    wire do_wr = aw_got & w_got & ~s_axi_bvalid;
    wire hit_ctrl = awaddr_q == ADDR_CTRL;
    wire hit_stat = awaddr_q == ADDR_STAT0 || awaddr_q == ADDR_STAT1;
    wire wr_map = hit_ctrl | hit_stat | (awaddr_q == ADDR_LIVE);
    assign status_wr = do_wr & hit_stat;

    wire [31:0] live = {22'h0, pdis_open, latch12, latch5,
        backup_ldo_enable, core_power_good, power_good_out,
        core_regulator_enable, io_regulator_enable, twelve_volt_fuse,
        five_volt_fuse};
    wire rd_ctrl = s_axi_araddr == ADDR_CTRL;
    wire rd_s0 = s_axi_araddr == ADDR_STAT0;
    wire rd_s1 = s_axi_araddr == ADDR_STAT1;
    wire rd_live = s_axi_araddr == ADDR_LIVE;
    wire rd_map = rd_ctrl | rd_s0 | rd_s1 | rd_live;
    wire [31:0] rd_mux = rd_ctrl ? {31'h0, dis_en}
        : rd_s0 ? {24'h0, status[7:0]}
        : rd_s1 ? {24'h0, status[15:8]}
        : rd_live ? live : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid & s_axi_awready) begin
                aw_got <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end else if (do_wr) begin
                aw_got <= 1'b0;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_got <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end else if (do_wr) begin
                w_got <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            dis_en <= CTRL_DIS_EN_RESET;
        end else begin
            if (do_wr) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_wr & hit_ctrl & wstrb_q[0]) begin
                dis_en <= wdata_q[CTRL_DIS_EN_BIT];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence status_clear;
        status_wr && ~|evt;
    endsequence
    sequence alert_held;
        !fault_alert_n && !status_wr;
    endsequence

    core_start_a: assert property ($rose(core_regulator_enable)
        |-> $past(s.core_en_pin) && $past(fout[F_IO_PG]))
        else $error("core regulator started out of order");
    core_pg_a: assert property ($rose(core_power_good)
        |-> $past(g_filt[F_CORE_PG].cnt) == CNT_W'(PG_DELAY - 1))
        else $error("core power-good rose before its delay");
    twelve_start_a: assert property ($rose(twelve_volt_fuse)
        |-> $past(s.five_good) && $past(s.twelve_good))
        else $error("12V fuse closed without both inputs");
    rev_open_a: assert property (s.rev_fast
        |=> !five_volt_fuse)
        else $error("5V fuse kept closed on reverse current");
    pg_drop_a: assert property (!fin[F_PG] |=> !power_good_out)
        else $error("power-good not dropped at once");
    pg_delay_a: assert property ($rose(power_good_out)
        |-> $past(g_filt[F_PG].cnt) == CNT_W'(PG_DELAY - 1))
        else $error("power-good rose before its delay");
    alert_hold_a: assert property (alert_held |=> !fault_alert_n)
        else $error("alert released without a status write");
    alert_clear_a: assert property (status_clear |=> fault_alert_n)
        else $error("alert still low after clear");
    hot12_off_a: assert property (latch12 |=> !twelve_volt_fuse)
        else $error("12V fuse closed while latched off");
    hot5_off_a: assert property (latch5 ##1 latch5
        |=> !five_volt_fuse && !io_regulator_enable
        && !core_regulator_enable)
        else $error("5V side running while latched off");
    pin_only_a: assert property (!s.permit && s.pdis
        |=> !five_volt_fuse && !twelve_volt_fuse)
        else $error("fuses closed with disable pin high");
    fw_gate_a: assert property (s.permit && !dis_en && s.pdis
        && s.five_good && !s.rev_fast && !latch5 |=> five_volt_fuse)
        else $error("disable pin acted without enable bit");
    status_lock_a: assert property (locked && !status_wr
        |=> (status & STAT_LOCK_MASK) == ($past(status) & STAT_LOCK_MASK))
        else $error("locked status bits changed");
endmodule : pmic_fault_sequencer

// ### verif/rail_model.sv
// Behavioural regulator rails and soft start seen by the sequencer
`timescale 1ns/1ps
module rail_model (
    input wire logic aclk,
    input wire logic io_en,
    input wire logic core_en,
    input wire logic sag,
    output logic io_up,
    output logic core_up,
    output logic ss_done
);
    logic [2:0] io_sh;
    logic [2:0] core_sh;
    ////////////////////////////////////////////////////////////////////
    // Rails ramp over three cycles; a dropped enable collapses at once
    always_ff @(posedge aclk) begin
        io_sh <= io_en ? {io_sh[1:0], 1'h1} : 3'h0;
        core_sh <= core_en ? {core_sh[1:0], 1'h1} : 3'h0;
    end
    assign io_up = io_sh[2];
    assign core_up = core_sh[2] & !sag;
    assign ss_done = io_sh[2];
endmodule : rail_model

// ### verif/testbench.sv
// Self-checking bench for the power fault sequencer
`timescale 1ns/1ps
module testbench;
    import pmic_seq_pkg::*;
    localparam int D = 8;
    logic aclk = 0, aresetn = 0, sag = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready;
    logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic five_volt_input_good = 0, twelve_volt_input_good = 0;
    logic reverse_current_fast = 0, core_reg_enable_pin = 0;
    logic twelve_output_settled = 0, five_over_temperature = 0;
    logic twelve_over_temperature = 0, five_early_thermal_warning = 0;
    logic twelve_early_thermal_warning = 0, five_fuse_current_limit = 0;
    logic twelve_fuse_current_limit = 0, core_current_limit = 0;
    logic io_current_limit = 0, five_output_clamp = 0;
    logic twelve_output_clamp = 0, power_disable_pin = 0;
    logic fw_disable_permit_pin = 0, core_above_threshold;
    logic io_above_threshold, io_soft_start_done, five_volt_fuse;
    logic twelve_volt_fuse, io_regulator_enable, core_regulator_enable;
    logic power_good_out, core_power_good, backup_ldo_enable;
    logic fault_alert_n;
    int failures = 0, checked = 0;
    always #20 aclk = ~aclk;
    pmic_fault_sequencer #(.PG_DELAY(D), .OC_DELAY(10)) dut_u (.*);
    rail_model rail_u (
        .aclk(aclk),
        .io_en(io_regulator_enable),
        .core_en(core_regulator_enable),
        .sag(sag),
        .io_up(io_above_threshold),
        .core_up(core_above_threshold),
        .ss_done(io_soft_start_done)
    );
    ////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : cyc
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One transfer at a time; waits on the handshake, giving up after 50 cycles
    task automatic bus(input bit w, input logic [7:0] a,
                       input logic [31:0] d, input logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid <= w;
        s_axi_bready <= w;
        s_axi_arvalid <= !w;
        s_axi_rready <= !w;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_bvalid && s_axi_bready) begin
                chk(s_axi_bresp, r);
                s_axi_bready <= 1'h0;
                n = 99;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                chk(s_axi_rdata, d);
                chk(s_axi_rresp, r);
                s_axi_rready <= 1'h0;
                n = 99;
            end
        end
        if (n != 99) failures++;
        #1;
    endtask : bus
    task automatic rs(input logic [15:0] e);
        bus(0, ADDR_STAT0, {24'h0, e[7:0]}, RESP_OKAY);
        bus(0, ADDR_STAT1, {24'h0, e[15:8]}, RESP_OKAY);
    endtask : rs
    task automatic clr;
        bus(1, ADDR_STAT1, 32'h0, RESP_OKAY);
        cyc(2);
        chk(fault_alert_n, 1'h1);
    endtask : clr
    task automatic ev(input int i, input logic v);
        @(posedge aclk);
        case (i)
            0: five_early_thermal_warning <= v;
            1: twelve_early_thermal_warning <= v;
            2: five_output_clamp <= v;
            3: twelve_output_clamp <= v;
            4: five_fuse_current_limit <= v;
            5: twelve_fuse_current_limit <= v;
            default: io_current_limit <= v;
        endcase
    endtask : ev
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        chk({fault_alert_n, five_volt_fuse, power_good_out}, 3'h4);
        bus(0, ADDR_CTRL, 32'h0, RESP_OKAY);
        bus(0, 8'h10, 32'h0, RESP_SLVERR);
        bus(1, 8'h10, 32'h1, RESP_SLVERR);
        bus(1, ADDR_LIVE, 32'h0, RESP_OKAY);
    endtask : t_reset
    task automatic t_power;
        @(posedge aclk);
        five_volt_input_good <= 1'h1;
        cyc(6);
        chk({five_volt_fuse, twelve_volt_fuse}, 2'h2);
        @(posedge aclk);
        twelve_volt_input_good <= 1'h1;
        cyc(3 * D + 20);
        chk(twelve_volt_fuse, 1'h1);
        chk({io_regulator_enable, core_regulator_enable}, 2'h2);
        @(posedge aclk);
        core_reg_enable_pin <= 1'h1;
        cyc(D);
        chk(core_power_good, 1'h0);
        cyc(2 * D + 20);
        chk({core_power_good, power_good_out}, 2'h3);
        chk({backup_ldo_enable, fault_alert_n}, 2'h3);
    endtask : t_power
    task automatic t_pg;
        @(posedge aclk);
        sag <= 1'h1;
        cyc(5);
        chk({power_good_out, fault_alert_n}, 2'h0);
        @(posedge aclk);
        sag <= 1'h0;
        cyc(D - 1);
        chk(power_good_out, 1'h0);
        cyc(2 * D + 10);
        chk(power_good_out, 1'h1);
        rs(16'h0010);
        clr();
    endtask : t_pg
    task automatic t_lock;
        @(posedge aclk);
        twelve_volt_input_good <= 1'h0;
        cyc(6);
        chk({twelve_volt_fuse, five_volt_fuse, power_good_out}, 3'h3);
        ev(2, 1'h1);
        core_current_limit <= 1'h1;
        cyc(810);
        ev(2, 1'h0);
        core_current_limit <= 1'h0;
        rs(16'h1080);
        twelve_volt_input_good <= 1'h1;
        clr();
        cyc(6);
        chk(twelve_volt_fuse, 1'h1);
    endtask : t_lock
    task automatic t_events;
        int bits[7] = '{ST_EOTW5, ST_EOTW12, ST_OV5, ST_TWELVE_OVERVOLTAGE_FLAG, ST_OC5,
                        ST_OC12, ST_OC_IO};
        ev(4, 1'h1);
        cyc(5);
        ev(4, 1'h0);
        cyc(8);
        chk(fault_alert_n, 1'h1);
        for (int i = 0; i < 7; i++) begin
            ev(i, 1'h1);
            cyc(830);
            chk({five_volt_fuse, twelve_volt_fuse}, 2'h3);
            chk(fault_alert_n, 1'h0);
            ev(i, 1'h0);
            rs(16'h1 << bits[i]);
            clr();
        end
    endtask : t_events
    task automatic t_disable;
        for (int k = 0; k < 8; k++) begin
            bus(1, ADDR_CTRL, {31'h0, k[1]}, RESP_OKAY);
            fw_disable_permit_pin <= k[2];
            power_disable_pin <= k[0];
            cyc(6);
            chk(five_volt_fuse, !(k[2] ? k[1] & k[0] : k[0]));
            chk(twelve_volt_fuse, five_volt_fuse);
        end
        chk(fault_alert_n, 1'h0);
        bus(0, ADDR_CTRL, 32'h1, RESP_OKAY);
        bus(1, ADDR_CTRL, 32'h0, RESP_OKAY);
        fw_disable_permit_pin <= 1'h0;
        power_disable_pin <= 1'h0;
        cyc(6);
        clr();
        reverse_current_fast <= 1'h1;
        cyc(6);
        chk(five_volt_fuse, 1'h0);
        reverse_current_fast <= 1'h0;
        cyc(6);
        chk(five_volt_fuse, 1'h1);
    endtask : t_disable
    task automatic t_thermal;
        @(posedge aclk);
        twelve_over_temperature <= 1'h1;
        cyc(6);
        chk({twelve_volt_fuse, five_volt_fuse}, 2'h1);
        twelve_over_temperature <= 1'h0;
        cyc(8);
        chk(twelve_volt_fuse, 1'h0);
        power_disable_pin <= 1'h1;
        cyc(6);
        power_disable_pin <= 1'h0;
        cyc(8);
        chk(twelve_volt_fuse, 1'h1);
        five_over_temperature <= 1'h1;
        cyc(6);
        five_over_temperature <= 1'h0;
        cyc(8);
        chk({five_volt_fuse, io_regulator_enable}, 2'h0);
        chk({core_regulator_enable, twelve_volt_fuse}, 2'h1);
        twelve_output_settled <= 1'h1;
        five_volt_input_good <= 1'h0;
        cyc(6);
        five_volt_input_good <= 1'h1;
        cyc(3 * D + 30);
        chk({five_volt_fuse, io_regulator_enable}, 2'h3);
        chk(backup_ldo_enable, 1'h0);
        clr();
    endtask : t_thermal
    ////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("failures %0d checked %0d", failures, checked);
        if (failures == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : complete_run
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        cyc(3);
        t_reset();
        t_power();
        t_pg();
        t_lock();
        t_events();
        t_disable();
        t_thermal();
        complete_run();
    end
    initial begin
        repeat (30000) @(posedge aclk);
        failures++;
        complete_run();
    end
endmodule : testbench
